// ---- rtl/cpm_clock_power.v ----
// Overview of operation
// - latch boot clock-select pins at reset pin rising edge; use them for sources.
// - code 00 uses crystal for main and usb, both plls on.
// - start main pll at reset, run on raw source until config written.
// - boot mode pins 11 turn clock-select pins into test selector.
// - pll output = 2*(M+8)*fin / ((P+2) * 2^S).
// - two plls, main for cpu/ahb/apb, usb pll alike for usb.
// - generate cpu, ahb and apb clocks from selected source.
// - per-peripheral clock gating by software; slow clocks without pll.
// - exactly four power modes: normal, slow, idle, sleep.
// - normal mode clocks cpu and every enabled peripheral.
// - slow mode bypasses pll, cpu clock straight from raw source.
// - idle mode gates only cpu core clock.
// - any cpu interrupt request ends idle mode.
// - sleep mode removes core power, wake logic stays alive.
// - only external wake interrupts or rtc alarm end sleep.
// - cpu clock held off during main pll lock once configured, except in slow mode, also after wake; runs raw during the boot lock.
// - usb clock raw after reset, low during lock after a usb config write, pll after.
// - new divider setting applied only after pll lock time.
`timescale 1ns/100ps
`include "cpm_defs.vh"
module cpm_clock_power (
  input wire mclk,
  input wire reset_n,
  input wire clk_en,
  input wire reset_pin_n,
  input wire [1:0] boot_clock_select_pins,
  input wire [1:0] boot_mode_pins,
  input wire [15:0] external_wake_interrupt,
  input wire rtc_alarm,
  input wire cpu_irq,
  input wire [15:0] fin_khz,
  input wire [15:0] lock_time,
  input wire main_pll_config_wr,
  input wire [7:0] main_pll_m,
  input wire [5:0] main_pll_p,
  input wire [1:0] main_pll_s,
  input wire usb_pll_config_wr,
  input wire [7:0] usb_pll_m,
  input wire [5:0] usb_pll_p,
  input wire [1:0] usb_pll_s,
  input wire clock_divider_config_wr,
  input wire [1:0] hdiv_sel,
  input wire pdiv_sel,
  input wire hclk_half3,
  input wire hclk_half4,
  input wire [15:0] peripheral_clock_gate,
  input wire mode_wr,
  input wire [1:0] mode_req,
  output reg boot_done_r,
  output reg main_src_ext_r,
  output reg usb_src_ext_r,
  output reg test_mode_r,
  output reg [1:0] test_sel_r,
  output reg main_pll_run_r,
  output reg usb_pll_run_r,
  output reg main_pll_locked_r,
  output reg usb_pll_locked_r,
  output reg sys_on_pll_r,
  output reg [19:0] main_pll_khz_r,
  output reg [19:0] usb_pll_khz_r,
  output reg [1:0] usb_clock_sel_r,
  output reg cpu_clock_en_r,
  output reg ahb_clk_en_r,
  output reg apb_clk_en_r,
  output reg [15:0] periph_clk_en_r,
  output reg [1:0] power_mode_r,
  output reg core_power_on_r
);
  localparam ST_NORMAL = `CPM_MODE_NORMAL;
  localparam ST_SLOW = `CPM_MODE_SLOW;
  localparam ST_IDLE = `CPM_MODE_IDLE;
  localparam ST_SLEEP = `CPM_MODE_SLEEP;

  // pll output frequency in khz, shared by both plls
  function [19:0] pll_khz;
    input [15:0] fin;
    input [7:0] mf;
    input [5:0] pf;
    input [1:0] sf;
    reg [8:0] m;
    reg [6:0] p;
    reg [26:0] num;
    reg [9:0] den;
    reg [26:0] quo;
    begin
      m = {1'b0, mf} + `CPM_PLL_M_OFFSET;
      p = {1'b0, pf} + `CPM_PLL_P_OFFSET;
      num = {m, 1'b0} * fin;
      den = {3'h0, p} << sf;
      quo = num / {17'h00000, den};
      pll_khz = quo[19:0];
    end
  endfunction

  // divide factors for ahb, and total for apb, in cpu clock cycles
  function [3:0] hdiv_factor;
    input [1:0] h;
    input half3;
    input half4;
    begin
      case (h)
        2'h0: hdiv_factor = `CPM_DIV_ONE;
        2'h1: hdiv_factor = `CPM_DIV_TWO;
        2'h2: hdiv_factor = half4 ? `CPM_DIV_EIGHT : `CPM_DIV_FOUR;
        default: hdiv_factor = half3 ? `CPM_DIV_SIX : `CPM_DIV_THREE;
      endcase
    end
  endfunction

  reg [`CPM_SYNC_W-1:0] sync1_r;
  reg [`CPM_SYNC_W-1:0] sync2_r;
  reg rst_pin_d_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg cfg_seen_r;
  reg relock_r;
  reg gap_r;
  reg sys_on_pll_nxt;
  reg [3:0] hdiv_pend_r;
  reg [4:0] pdiv_pend_r;
  reg div_pend_r;
  reg main_lock_d_r;
  reg usb_cfg_seen_r;

  wire [`CPM_SYNC_W-1:0] pins_in;
  wire rst_pin_rise;
  wire [1:0] sel_s;
  wire [1:0] bmode_s;
  wire wake_any;
  wire irq_s;
  wire main_start;
  wire usb_start;
  wire main_locked;
  wire usb_locked;
  wire main_lock_done;
  wire cpu_tick;
  wire div_apply;
  wire hclk_en;
  wire pclk_en;
  wire [3:0] hdiv_new;

  assign pins_in = {cpu_irq, rtc_alarm, external_wake_interrupt, boot_mode_pins,
                    boot_clock_select_pins, reset_pin_n};

  // pins cross in through two stages; only the second stage is decoded
  // reset pin stages start at its idle high level, else a false rise follows reset
  always @(posedge mclk) begin
    if (!reset_n) begin
      sync1_r <= {{(`CPM_SYNC_W-1){1'b0}}, 1'b1};
      sync2_r <= {{(`CPM_SYNC_W-1){1'b0}}, 1'b1};
      rst_pin_d_r <= 1'b1;
    end else if (clk_en) begin
      sync1_r <= pins_in;
      sync2_r <= sync1_r;
      rst_pin_d_r <= sync2_r[`CPM_SYNC_RST];
    end
  end

  assign rst_pin_rise = sync2_r[`CPM_SYNC_RST] & ~rst_pin_d_r;
  assign sel_s = sync2_r[`CPM_SYNC_SEL_HI:`CPM_SYNC_SEL_LO];
  assign bmode_s = sync2_r[`CPM_SYNC_MODE_HI:`CPM_SYNC_MODE_LO];
  assign wake_any = |sync2_r[`CPM_SYNC_WAKE_HI:`CPM_SYNC_WAKE_LO] | sync2_r[`CPM_SYNC_RTC];
  assign irq_s = sync2_r[`CPM_SYNC_IRQ];

  // plls restart at boot latch and on their own config write; main pll also on wake from sleep or a non-slow mode write in slow
  assign main_start = rst_pin_rise | main_pll_config_wr |
                      (state_r == ST_SLEEP && wake_any) |
                      (state_r == ST_SLOW && mode_wr && mode_req != ST_SLOW);
  assign usb_start = rst_pin_rise | usb_pll_config_wr;

  cpm_lock_cnt u_main_lock (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .start(main_start),
    .load(lock_time),
    .locked_r(main_locked)
  );

  cpm_lock_cnt u_usb_lock (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .start(usb_start),
    .load(lock_time),
    .locked_r(usb_locked)
  );

  assign main_lock_done = main_locked & ~main_lock_d_r & ~main_start;

  // boot latch, pll bookkeeping
  always @(posedge mclk) begin
    if (!reset_n) begin
      boot_done_r <= 1'b0;
      main_src_ext_r <= 1'b0;
      usb_src_ext_r <= 1'b0;
      test_mode_r <= 1'b0;
      test_sel_r <= 2'h0;
      main_pll_khz_r <= 20'h00000;
      usb_pll_khz_r <= 20'h00000;
      main_pll_locked_r <= 1'b0;
      usb_pll_locked_r <= 1'b0;
      main_lock_d_r <= 1'b0;
      cfg_seen_r <= 1'b0;
      usb_cfg_seen_r <= 1'b0;
      usb_clock_sel_r <= `CPM_USB_RAW;
    end else if (clk_en) begin
      main_lock_d_r <= main_locked;
      main_pll_locked_r <= main_locked;
      usb_pll_locked_r <= usb_locked;
      if (rst_pin_rise) begin
        boot_done_r <= 1'b1;
        main_src_ext_r <= sel_s[`CPM_SEL_MAIN_EXT_BIT];
        usb_src_ext_r <= sel_s[`CPM_SEL_USB_EXT_BIT];
        test_mode_r <= (bmode_s == `CPM_BOOT_TEST_CODE);
        test_sel_r <= (bmode_s == `CPM_BOOT_TEST_CODE) ? sel_s : 2'h0;
        main_pll_khz_r <= pll_khz(fin_khz, main_pll_m, main_pll_p, main_pll_s);
        usb_pll_khz_r <= pll_khz(fin_khz, usb_pll_m, usb_pll_p, usb_pll_s);
        cfg_seen_r <= 1'b0;
        usb_cfg_seen_r <= 1'b0;
        usb_clock_sel_r <= `CPM_USB_RAW;
      end else begin
        if (main_pll_config_wr) begin
          cfg_seen_r <= 1'b1;
          main_pll_khz_r <= pll_khz(fin_khz, main_pll_m, main_pll_p, main_pll_s);
        end
        if (usb_pll_config_wr) begin
          usb_cfg_seen_r <= 1'b1;
          usb_pll_khz_r <= pll_khz(fin_khz, usb_pll_m, usb_pll_p, usb_pll_s);
          usb_clock_sel_r <= `CPM_USB_LOW;
        end else if (usb_cfg_seen_r && usb_locked) begin
          usb_clock_sel_r <= `CPM_USB_PLL;
        end
      end
    end
  end

  // power mode sequencer
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_NORMAL: begin
        if (mode_wr) begin
          state_nxt = mode_req;
        end
      end
      ST_SLOW: begin
        if (mode_wr && mode_req != ST_SLEEP) begin
          state_nxt = mode_req;
        end
      end
      ST_IDLE: begin
        if (irq_s) begin
          state_nxt = ST_NORMAL;
        end
      end
      ST_SLEEP: begin
        if (wake_any) begin
          state_nxt = ST_NORMAL;
        end
      end
      default: state_nxt = ST_NORMAL;
    endcase
  end

  // the pll path is used only once configured, locked and not in slow mode
  always @* begin
    sys_on_pll_nxt = cfg_seen_r & main_locked & ~relock_r & (state_r != ST_SLOW);
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      state_r <= ST_NORMAL;
      relock_r <= 1'b0;
      sys_on_pll_r <= 1'b0;
      gap_r <= 1'b0;
      main_pll_run_r <= 1'b0;
      usb_pll_run_r <= 1'b0;
      power_mode_r <= `CPM_MODE_NORMAL;
      core_power_on_r <= 1'b1;
    end else if (clk_en) begin
      state_r <= state_nxt;
      power_mode_r <= state_nxt;
      core_power_on_r <= (state_nxt != ST_SLEEP);
      if (main_start) begin
        relock_r <= 1'b1;
      end else if (main_lock_done) begin
        relock_r <= 1'b0;
      end
      // a source change is followed by a dead cycle before the cpu clock returns
      sys_on_pll_r <= sys_on_pll_nxt;
      gap_r <= (sys_on_pll_nxt != sys_on_pll_r);
      if (rst_pin_rise) begin
        main_pll_run_r <= 1'b1;
        usb_pll_run_r <= 1'b1;
      end else if (boot_done_r) begin
        main_pll_run_r <= (state_nxt != ST_SLOW) && (state_nxt != ST_SLEEP);
        usb_pll_run_r <= (state_nxt != ST_SLEEP);
      end
    end
  end

  // cpu runs on the raw source before configuration; stops for lock waits once configured, except in slow mode
  assign cpu_tick = boot_done_r & core_power_on_r & (state_r != ST_IDLE) & ~gap_r &
                    (sys_on_pll_nxt == sys_on_pll_r) &
                    ~(cfg_seen_r & relock_r & (state_r != ST_SLOW));

  assign hdiv_new = hdiv_factor(hdiv_sel, hclk_half3, hclk_half4);

  // divider setting applies once the main pll is locked with no relock pending
  always @(posedge mclk) begin
    if (!reset_n) begin
      hdiv_pend_r <= `CPM_DIV_ONE;
      pdiv_pend_r <= {1'b0, `CPM_DIV_ONE};
      div_pend_r <= 1'b0;
    end else if (clk_en) begin
      if (clock_divider_config_wr) begin
        hdiv_pend_r <= hdiv_new;
        pdiv_pend_r <= pdiv_sel ? {hdiv_new, 1'b0} : {1'b0, hdiv_new};
        div_pend_r <= 1'b1;
      end else if (div_apply) begin
        div_pend_r <= 1'b0;
      end
    end
  end

  assign div_apply = div_pend_r & main_locked & ~relock_r;

  cpm_clk_div u_div (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .tick(cpu_tick),
    .apply(div_apply),
    .hdiv_in(hdiv_pend_r),
    .pdiv_in(pdiv_pend_r),
    .hclk_en_r(hclk_en),
    .pclk_en_r(pclk_en)
  );

  // the bus clocks keep running through idle; only the core is held
  always @(posedge mclk) begin
    if (!reset_n) begin
      cpu_clock_en_r <= 1'b0;
      ahb_clk_en_r <= 1'b0;
      apb_clk_en_r <= 1'b0;
      periph_clk_en_r <= 16'h0000;
    end else if (clk_en) begin
      cpu_clock_en_r <= cpu_tick;
      ahb_clk_en_r <= hclk_en | (state_r == ST_IDLE && boot_done_r);
      apb_clk_en_r <= pclk_en | (state_r == ST_IDLE && boot_done_r);
      periph_clk_en_r <= (core_power_on_r && boot_done_r) ? peripheral_clock_gate
                                                          : 16'h0000;
    end
  end
endmodule // cpm_clock_power

// ---- rtl/cpm_defs.vh ----
`ifndef CPM_DEFS_VH
`define CPM_DEFS_VH

// boot clock selection codes
`define CPM_SEL_BITS 2
`define CPM_SEL_MAIN_EXT_BIT 1
`define CPM_SEL_USB_EXT_BIT 0
`define CPM_BOOT_TEST_CODE 2'h3

// power mode encodings
`define CPM_MODE_NORMAL 2'h0
`define CPM_MODE_SLOW 2'h1
`define CPM_MODE_IDLE 2'h2
`define CPM_MODE_SLEEP 2'h3

// usb clock source encodings
`define CPM_USB_RAW 2'h0
`define CPM_USB_LOW 2'h1
`define CPM_USB_PLL 2'h2

// pll arithmetic offsets
`define CPM_PLL_M_OFFSET 9'h008
`define CPM_PLL_P_OFFSET 7'h02

// divider factors
`define CPM_DIV_ONE 4'h1
`define CPM_DIV_TWO 4'h2
`define CPM_DIV_THREE 4'h3
`define CPM_DIV_FOUR 4'h4
`define CPM_DIV_SIX 4'h6
`define CPM_DIV_EIGHT 4'h8

// synchronised pin vector layout
`define CPM_SYNC_W 23
`define CPM_SYNC_RST 0
`define CPM_SYNC_SEL_LO 1
`define CPM_SYNC_SEL_HI 2
`define CPM_SYNC_MODE_LO 3
`define CPM_SYNC_MODE_HI 4
`define CPM_SYNC_WAKE_LO 5
`define CPM_SYNC_WAKE_HI 20
`define CPM_SYNC_RTC 21
`define CPM_SYNC_IRQ 22

`endif

// ---- rtl/cpm_lock_cnt.v ----
`timescale 1ns/100ps
`include "cpm_defs.vh"
module cpm_lock_cnt (
  input wire mclk,
  input wire reset_n,
  input wire clk_en,
  input wire start,
  input wire [15:0] load,
  output reg locked_r
);
  reg [15:0] count_r;

  always @(posedge mclk) begin
    if (!reset_n) begin
      count_r <= 16'h0000;
      locked_r <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        count_r <= load;
        locked_r <= 1'b0;
      end else if (count_r != 16'h0000) begin
        count_r <= count_r - 16'h0001;
      end else begin
        locked_r <= 1'b1;
      end
    end
  end
endmodule // cpm_lock_cnt

// ---- rtl/cpm_clk_div.v ----
`timescale 1ns/100ps
`include "cpm_defs.vh"
module cpm_clk_div (
  input wire mclk,
  input wire reset_n,
  input wire clk_en,
  input wire tick,
  input wire apply,
  input wire [3:0] hdiv_in,
  input wire [4:0] pdiv_in,
  output reg hclk_en_r,
  output reg pclk_en_r
);
  reg [3:0] hdiv_r;
  reg [4:0] pdiv_r;
  reg [3:0] hcnt_r;
  reg [4:0] pcnt_r;
  wire h_wrap;
  wire p_wrap;

  assign h_wrap = (hcnt_r == hdiv_r - `CPM_DIV_ONE);
  assign p_wrap = (pcnt_r == pdiv_r - {1'b0, `CPM_DIV_ONE});

  // counters restart on a new ratio so the first period is never short
  always @(posedge mclk) begin
    if (!reset_n) begin
      hdiv_r <= `CPM_DIV_ONE;
      pdiv_r <= {1'b0, `CPM_DIV_ONE};
      hcnt_r <= 4'h0;
      pcnt_r <= 5'h00;
      hclk_en_r <= 1'b0;
      pclk_en_r <= 1'b0;
    end else if (clk_en) begin
      if (apply) begin
        hdiv_r <= hdiv_in;
        pdiv_r <= pdiv_in;
        hcnt_r <= 4'h0;
        pcnt_r <= 5'h00;
        hclk_en_r <= 1'b0;
        pclk_en_r <= 1'b0;
      end else if (tick) begin
        hcnt_r <= h_wrap ? 4'h0 : hcnt_r + 4'h1;
        pcnt_r <= p_wrap ? 5'h00 : pcnt_r + 5'h01;
        hclk_en_r <= h_wrap;
        pclk_en_r <= p_wrap;
      end else begin
        hclk_en_r <= 1'b0;
        pclk_en_r <= 1'b0;
      end
    end
  end
endmodule // cpm_clk_div

// ---- verification/cpm_chk_assertions.sv ----
`timescale 1ns/100ps
`include "cpm_defs.vh"
module cpm_chk (
  input logic mclk,
  input logic reset_n,
  input logic clk_en,
  input logic boot_done_r,
  input logic core_power_on_r,
  input logic cpu_clock_en_r,
  input logic cpu_irq,
  input logic mode_wr,
  input logic [1:0] mode_req,
  input logic [1:0] power_mode_r,
  input logic main_pll_config_wr,
  input logic [7:0] main_pll_m,
  input logic [5:0] main_pll_p,
  input logic [1:0] main_pll_s,
  input logic [15:0] fin_khz,
  input logic [15:0] lock_time,
  input logic [19:0] main_pll_khz_r,
  input logic sys_on_pll_r,
  input logic [15:0] peripheral_clock_gate,
  input logic [15:0] periph_clk_en_r
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  logic cfg_seen_r;
  // sticky until reset: the raw source must stand until the first config write
  always @(posedge mclk) begin
    if (!reset_n) begin
      cfg_seen_r <= 1'b0;
    end else if (main_pll_config_wr && clk_en) begin
      cfg_seen_r <= 1'b1;
    end
  end
  chk_sleep_power: assert property (
    $stable(power_mode_r) |-> core_power_on_r == (power_mode_r != `CPM_MODE_SLEEP))
    else $error("core power does not follow sleep mode");
  chk_idle_cpu_off: assert property (
    power_mode_r == `CPM_MODE_IDLE && $stable(power_mode_r) |-> !cpu_clock_en_r)
    else $error("cpu clock ticks in idle");
  chk_mode_taken: assert property (
    mode_wr && clk_en && boot_done_r && power_mode_r == `CPM_MODE_NORMAL
    |=> power_mode_r == $past(mode_req))
    else $error("mode request not taken");
  chk_pll_freq: assert property (
    main_pll_config_wr && clk_en && boot_done_r |=> main_pll_khz_r == 20'((32'd2 *
    ($past(main_pll_m) + 32'd8) * $past(fin_khz)) / (($past(main_pll_p) + 32'd2) << $past(main_pll_s))))
    else $error("pll frequency wrong");
  chk_cpu_hold: assert property (
    main_pll_config_wr && clk_en && boot_done_r && power_mode_r == `CPM_MODE_NORMAL &&
    lock_time >= 16'h0004 |-> ##2 !cpu_clock_en_r [*3])
    else $error("cpu clock runs during lock");
  chk_raw_until_cfg: assert property (!cfg_seen_r |-> !sys_on_pll_r)
    else $error("pll used before config write");
  chk_periph_gate: assert property (
    $past(core_power_on_r) && $past(boot_done_r) && core_power_on_r
    |-> periph_clk_en_r == $past(peripheral_clock_gate))
    else $error("peripheral gates do not follow enables");
  chk_irq_idle_exit: assert property (
    power_mode_r == `CPM_MODE_IDLE && cpu_irq |-> ##[1:4] power_mode_r == `CPM_MODE_NORMAL)
    else $error("interrupt did not end idle");
endmodule // cpm_chk

// ---- verification/cpm_ext_model.sv ----
`timescale 1ns/100ps
module cpm_ext_model (
  output logic reset_pin_n,
  output logic [15:0] external_wake_interrupt,
  output logic rtc_alarm,
  output logic cpu_irq,
  input logic mclk
);
  initial begin
    reset_pin_n = 1'b1;
    external_wake_interrupt = 16'h0000;
    rtc_alarm = 1'b0;
    cpu_irq = 1'b0;
  end
  // low for 3 cycles, one more than the minimum
  task automatic pin_pulse();
    @(posedge mclk);
    reset_pin_n <= 1'b0;
    repeat (3) @(posedge mclk);
    reset_pin_n <= 1'b1;
  endtask
  // 0 irq, 1..16 one wake line, 17 alarm; held past the synchronisers
  task automatic raise(input int kind);
    @(posedge mclk);
    cpu_irq <= (kind == 0);
    external_wake_interrupt <= (kind > 0 && kind < 17) ? 16'h0001 << (kind - 1) : 16'h0000;
    rtc_alarm <= (kind == 17);
    repeat (6) @(posedge mclk);
    cpu_irq <= 1'b0;
    external_wake_interrupt <= 16'h0000;
    rtc_alarm <= 1'b0;
  endtask
endmodule // cpm_ext_model

// ---- verification/cpm_clock_power_tb_top.sv ----
`timescale 1ns/100ps
`include "cpm_defs.vh"
module cpm_clock_power_tb_top;
  logic mclk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, pdiv_sel = 1'b0;
  logic main_pll_config_wr = 1'b0, usb_pll_config_wr = 1'b0, clock_divider_config_wr = 1'b0;
  logic hclk_half3 = 1'b0, hclk_half4 = 1'b0, mode_wr = 1'b0;
  logic [1:0] boot_clock_select_pins = 2'h0, boot_mode_pins = 2'h0, hdiv_sel = 2'h0;
  logic [1:0] mode_req = 2'h0, main_pll_s = 2'h0, usb_pll_s = 2'h0;
  logic [7:0] main_pll_m = 8'h00, usb_pll_m = 8'h00;
  logic [5:0] main_pll_p = 6'h00, usb_pll_p = 6'h00;
  logic [15:0] fin_khz = 16'h03e8, lock_time = 16'h0004, peripheral_clock_gate = 16'h0000;
  logic reset_pin_n, rtc_alarm, cpu_irq, boot_done_r, main_src_ext_r, usb_src_ext_r;
  logic test_mode_r, sys_on_pll_r, cpu_clock_en_r, ahb_clk_en_r, apb_clk_en_r, bd_q = 1'b0;
  logic [15:0] external_wake_interrupt;
  logic [1:0] test_sel_r, usb_clock_sel_r, power_mode_r, m_q = 2'h0;
  logic [19:0] main_pll_khz_r, kexp = 20'h00000, k_q = 20'h00000;
  logic [19:0] qb[$], qk[$], qm[$];
  int n_fail = 0, samples_checked = 0, nc = 0, na = 0, np = 0;
  wire [19:0] boot_seen = {15'h0, {main_src_ext_r, usb_src_ext_r} & ~{2{test_mode_r}},
    test_mode_r, test_sel_r};
  always #4 mclk = ~mclk;
  cpm_ext_model u_ext (.*);
  cpm_clock_power DUT (.*, .main_pll_run_r(), .usb_pll_run_r(), .main_pll_locked_r(),
    .usb_pll_locked_r(), .usb_pll_khz_r(), .periph_clk_en_r(), .core_power_on_r());
  task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pop(ref logic [19:0] q[$], input logic [19:0] seen, input string what);
    check(seen, q.size() ? q.pop_front() : 20'hxxxxx, what);
  endtask
  // results are compared when they appear, in order of request
  always @(negedge mclk) begin
    if (reset_n && boot_done_r && !bd_q)
      pop(qb, boot_seen, "boot");
    if (reset_n && main_pll_khz_r != k_q)
      pop(qk, main_pll_khz_r, "khz");
    if (reset_n && power_mode_r != m_q)
      pop(qm, {18'h0, power_mode_r}, "mode");
    bd_q <= boot_done_r;
    k_q <= main_pll_khz_r;
    m_q <= power_mode_r;
  end
  always @(posedge mclk) begin
    nc += int'(cpu_clock_en_r);
    na += int'(ahb_clk_en_r);
    np += int'(apb_clk_en_r);
  end
  task automatic boot(input logic [1:0] sel, input logic [1:0] bm);
    @(posedge mclk);
    reset_n <= 1'b0;
    boot_clock_select_pins <= sel;
    boot_mode_pins <= bm;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    kexp = 20'((32'd2 * (main_pll_m + 32'd8) * fin_khz) / ((main_pll_p + 32'd2) << main_pll_s));
    qk.push_back(kexp);
    qb.push_back(bm == `CPM_BOOT_TEST_CODE ? {17'h0, 1'b1, sel} : {15'h0, sel, 3'h0});
    u_ext.pin_pulse();
    repeat (8) @(posedge mclk);
  endtask
  task automatic pll(input int gap);
    logic [15:0] r;
    logic [19:0] e;
    r = 16'($urandom);
    e = 20'((32'd2 * (r[15:8] + 32'd8) * fin_khz) / ((r[7:2] + 32'd2) << r[1:0]));
    if (e != kexp)
      qk.push_back(e);
    kexp = e;
    @(posedge mclk);
    main_pll_config_wr <= 1'b1;
    {main_pll_m, main_pll_p, main_pll_s} <= r;
    @(posedge mclk);
    main_pll_config_wr <= 1'b0;
    repeat (gap) @(posedge mclk);
  endtask
  task automatic mode(input logic [1:0] r, input logic chg);
    if (chg)
      qm.push_back({18'h0, r});
    @(posedge mclk);
    mode_wr <= 1'b1;
    mode_req <= r;
    @(posedge mclk);
    mode_wr <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
  // tolerance of one divided tick covers the window edges
  task automatic div(input logic [4:0] cfg, input int fh, input int fp);
    @(posedge mclk);
    clock_divider_config_wr <= 1'b1;
    {hdiv_sel, pdiv_sel, hclk_half3, hclk_half4} <= cfg;
    @(posedge mclk);
    clock_divider_config_wr <= 1'b0;
    repeat (24) @(posedge mclk);
    nc = 0;
    na = 0;
    np = 0;
    repeat (96) @(posedge mclk);
    check({19'h0, nc > 0 && na * fh >= nc - fh && na * fh <= nc + fh &&
      np * fp >= nc - fp && np * fp <= nc + fp}, 20'h00001, "bus rates");
  endtask
  task automatic finish_test();
    if (qb.size() + qk.size() + qm.size() != 0)
      n_fail++;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h0d31));
    repeat (20) @(posedge mclk);
    fin_khz <= 16'(1000 + $urandom % 2000);
    peripheral_clock_gate <= 16'($urandom);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++)
      boot(2'(i), 2'($urandom % 3));
    boot(2'($urandom), `CPM_BOOT_TEST_CODE);
    boot(2'h0, 2'h0);
    check({18'h0, sys_on_pll_r, usb_clock_sel_r == `CPM_USB_RAW}, 20'h1, "raw");
    pll(12);
    check({19'h0, sys_on_pll_r}, 20'h00001, "sys_on_pll_r");
    pll(1);
    for (int i = 0; i < 4; i++)
      pll(12);
    @(posedge mclk);
    usb_pll_config_wr <= 1'b1;
    {usb_pll_m, usb_pll_p, usb_pll_s} <= 16'($urandom);
    @(posedge mclk);
    usb_pll_config_wr <= 1'b0;
    #1;
    check({18'h0, usb_clock_sel_r}, {18'h0, `CPM_USB_LOW}, "usb low");
    repeat (12) @(posedge mclk);
    check({18'h0, usb_clock_sel_r}, {18'h0, `CPM_USB_PLL}, "usb pll");
    peripheral_clock_gate <= 16'($urandom);
    div(5'h00, 1, 1);
    div(5'h0c, 2, 4);
    div(5'h1e, 6, 12);
    div(5'h11, 8, 8);
    mode(`CPM_MODE_SLOW, 1'b1);
    mode(`CPM_MODE_SLEEP, 1'b0);
    mode(`CPM_MODE_NORMAL, 1'b1);
    mode(`CPM_MODE_IDLE, 1'b1);
    mode(`CPM_MODE_NORMAL, 1'b0);
    qm.push_back({18'h0, `CPM_MODE_NORMAL});
    u_ext.raise(0);
    mode(`CPM_MODE_SLEEP, 1'b1);
    u_ext.raise(0);
    qm.push_back({18'h0, `CPM_MODE_NORMAL});
    u_ext.raise(1 + $urandom % 16);
    repeat (12) @(posedge mclk);
    mode(`CPM_MODE_SLEEP, 1'b1);
    qm.push_back({18'h0, `CPM_MODE_NORMAL});
    u_ext.raise(17);
    repeat (20) @(posedge mclk);
    finish_test();
  end
endmodule // cpm_clock_power_tb_top
bind cpm_clock_power cpm_chk u_chk (.*);
